// >>> pkg/chan_delay_map.svh
/*
 register offsets, field positions and reset values for the
 per-channel delay and output mux block.
 assumes: included by bare name from package and logic files.
*/
`ifndef CHAN_DELAY_MAP_SVH
`define CHAN_DELAY_MAP_SVH

`define CH0_FINE_DELAY_OFS       12'h0CB
`define CH0_COARSE_DELAY_OFS     12'h0CC
`define CH0_SLIP_LOW_OFS         12'h0CD
`define CH0_SLIP_HIGH_OFS        12'h0CE
`define CH0_SOURCE_SELECT_OFS    12'h0CF
`define CH0_IDLE_LEVEL_OFS       12'h0D0
`define CH0_CONTROL_OFS          12'h0C8
`define CH0_DIV_LOW_OFS          12'h0C9
`define CH0_DIV_HIGH_OFS         12'h0CA
`define CH_STRIDE                12'h00A
`define SLIP_REQUEST_ADDR        12'h3F0
`define FINE_DELAY_MAX           5'h17
`define COARSE_DELAY_MAX         5'h11
`define CTRL_SLIP_EN_BIT         5
`define CTRL_REPEAT_EN_BIT       1
`define CTRL_MODE_HI_BIT         3
`define CTRL_MODE_LO_BIT         2
`define IDLE_HI_BIT              7
`define IDLE_LO_BIT              6
`define SEL_DIVIDER              2'h0
`define SEL_ANALOG               2'h1
`define SEL_PAIR                 2'h2
`define SEL_VCO                  2'h3
`define MODE_PULSE_GEN           2'h3
`define IDLE_NORMAL              2'h0
`define IDLE_LOGIC_LOW           2'h2
`define REPEAT_RESET_DEVICE_CLOCK_OUTPUT        1'h1
`define REPEAT_RESET_PULSE       1'h0
`define DIV_ONE                  12'h001

`endif

// >>> pkg/chan_delay_pkg.sv
/*
 types for the channel delay block.
 assumes: map header available on the include path.
*/
package chan_delay_pkg;
`include "chan_delay_map.svh"

    typedef struct packed {
        logic [4:0]  fine;
        logic [4:0]  coarse;
        logic [11:0] repeat_count;
        logic [1:0]  source;
        logic [1:0]  idle;
        logic [7:0]  control;
        logic [11:0] divider;
    } chan_cfg_t;

    typedef struct packed {
        logic        shift;
        logic [4:0]  fine;
        logic [4:0]  coarse;
        logic        out;
    } chan_out_t;

    typedef enum logic [1:0] {
        SLIP_IDLE,
        SLIP_RUN
    } slip_state_t;

endpackage

// >>> logic/delay_code_hold.sv
/*
 holds the last delay code that was in range; codes above the
 limit leave the applied code unchanged.
 assumes: single clock, synchronous active-high reset.
*/
module delay_code_hold
    import chan_delay_pkg::*;
#(
    parameter logic [4:0] LIMIT = 5'h17
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [4:0] code,
    output logic [4:0]      applied
);
    logic [4:0] applied_ff;
    wire        in_range = (code <= LIMIT);
    wire  [4:0] nxt_applied = in_range ? code : applied_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            applied_ff <= 5'h00;
        end else begin
            applied_ff <= nxt_applied;
        end
    end
    assign applied = applied_ff;

    a_hold_range: assert property (@(posedge clk) disable iff (srst)
        !in_range |=> applied_ff == $past(applied_ff))
        else $error("out of range code changed delay");
    a_take_code: assert property (@(posedge clk) disable iff (srst)
        in_range |=> applied_ff == $past(code))
        else $error("in range code not applied");
endmodule

// >>> logic/slip_repeater.sv
/*
 turns one slip event into a train of one-cycle shift pulses.
 assumes: events are one-cycle pulses in the core clock domain.
*/
module slip_repeater
    import chan_delay_pkg::*;
#(
    parameter int CW = 12
) (
    input  wire logic          clk,
    input  wire logic          srst,
    input  wire logic          event_in,
    input  wire logic          slip_en,
    input  wire logic          repeat_en,
    input  wire logic [CW-1:0] count,
    output logic               shift
);
    slip_state_t    state_ff;
    slip_state_t    nxt_state;
    logic [CW-1:0]  left_ff;
    logic [CW-1:0]  nxt_left;
    logic           shift_ff;
    logic           nxt_shift;

    wire start = event_in && slip_en && state_ff == SLIP_IDLE;
    wire multi = repeat_en && count > CW'(1);

    always_comb begin
        nxt_state = state_ff;
        nxt_left  = left_ff;
        nxt_shift = 1'b0;
        case (state_ff)
            SLIP_IDLE: begin
                if (start && !repeat_en) begin
                    nxt_shift = 1'b1;
                end else if (start && count != '0) begin
                    nxt_shift = 1'b1;
                    if (multi) begin
                        nxt_left  = count - CW'(1);
                        nxt_state = SLIP_RUN;
                    end
                end
            end
            SLIP_RUN: begin
                nxt_shift = 1'b1;
                nxt_left  = left_ff - CW'(1);
                if (left_ff == CW'(1)) begin
                    nxt_state = SLIP_IDLE;
                end
            end
            default: nxt_state = SLIP_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= SLIP_IDLE;
            left_ff  <= '0;
            shift_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            left_ff  <= nxt_left;
            shift_ff <= nxt_shift;
        end
    end
    assign shift = shift_ff;

    a_single_slip: assert property (@(posedge clk) disable iff (srst)
        start && !repeat_en |=> shift_ff ##1 !shift_ff)
        else $error("single slip not one pulse");
    a_repeat_two: assert property (@(posedge clk) disable iff (srst)
        start && repeat_en && count == CW'(2)
        |=> shift_ff [*2] ##1 !shift_ff)
        else $error("repeat of two wrong");
    a_no_slip: assert property (@(posedge clk) disable iff (srst)
        event_in && !slip_en && state_ff == SLIP_IDLE |=> !shift_ff)
        else $error("slip while disabled");
endmodule

// >>> logic/clock_channel_delay_mux.sv
/*
 per-channel delay, repeat-slip and output source selection for
 fourteen clock channels, with an apb register slave.
 assumes: channel clocks arrive as synchronous samples; slip
 sources are one-cycle pulses; apb master follows the protocol.
*/
// Local design decision: the APB register port.
// Behaviour
// - five-bit fine delay code, 24 steps of 25 ps each
// - fine codes above 23 leave analog delay unchanged
// - five-bit coarse delay code, 18 half-VCO-cycle steps
// - coarse codes above 17 leave coarse delay unchanged
// - 12-bit repeat count: low byte, then low nibble of next register
// - with repeat allowed each slip event repeats count times
// - source select: divider, analog delay, pair channel, raw VCO
// - divider setpoint of one also yields the undivided VCO clock
// - idle level select acts only in pulse generator mode
// - repeat allow defaults 0 on pulse channels, 1 on clock channels
// - slip allowed, repeat off: one VCO cycle per slip request
`include "chan_delay_map.svh"
module clock_channel_delay_mux
    import chan_delay_pkg::*;
#(
    parameter int                NCH         = 14,
    parameter logic [NCH-1:0]    PULSE_CHANS = 14'h2AAA
) (
    input  wire logic            CORE_CLK,
    input  wire logic            SRST,
    input  wire logic            PSEL,
    input  wire logic            PENABLE,
    input  wire logic            PWRITE,
    input  wire logic [11:0]     PADDR,
    input  wire logic [31:0]     PWDATA,
    output logic      [31:0]     PRDATA,
    output logic                 PREADY,
    output logic                 PSLVERR,
    input  wire logic            GENERAL_INPUT_PIN_SLIP,
    input  wire logic            SYNC_SLIP,
    input  wire logic            PULSE_GEN_SLIP,
    input  wire logic [NCH-1:0]  DIVIDER_CLK,
    input  wire logic [NCH-1:0]  ANALOG_DELAY_CLK,
    input  wire logic            VCO_CLK,
    output logic [NCH-1:0]       CHANNEL_OUT,
    output logic [NCH-1:0]       IDLE_AT_VCM,
    output logic [NCH-1:0]       SLIP_SHIFT,
    output logic [NCH*5-1:0]     FINE_DELAY,
    output logic [NCH*5-1:0]     COARSE_DELAY
);
    if (NCH < 2 || NCH > 14 || NCH % 2 != 0) begin : g_bad_nch
        $error("channel count must be even, 2 to 14");
    end

    ////////////////////////////////////////////////////////////////////
    // apb decode
    wire        apb_access = PSEL && PENABLE;
    wire        apb_wr     = apb_access && PWRITE;
    wire [11:0] word_idx   = {2'h0, PADDR[11:2]};
    wire        aligned    = PADDR[1:0] == 2'h0;
    wire        slip_hit   = aligned && word_idx == `SLIP_REQUEST_ADDR;
    wire        spi_slip   = apb_wr && slip_hit && PWDATA[0];

    logic [NCH-1:0] ch_hit;
    logic [8:0]     ch_field [NCH];
    logic [31:0]    rd_mux;
    logic [31:0]    prdata_ff;

    chan_cfg_t      cfg_ff [NCH];
    logic [NCH-1:0] shift_w;
    logic [NCH-1:0] chan_src;
    wire            slip_event = GENERAL_INPUT_PIN_SLIP || SYNC_SLIP ||
                                 PULSE_GEN_SLIP || spi_slip;

    ////////////////////////////////////////////////////////////////////
    // per-channel registers and datapath
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gch
            localparam logic [11:0] BASE =
                12'(`CH0_CONTROL_OFS + g * `CH_STRIDE);
            wire [11:0] rel  = word_idx - BASE;
            wire        hit  = aligned && word_idx >= BASE &&
                               rel < 12'h009;
            wire        wr   = apb_wr && hit;
            wire [7:0]  wd   = PWDATA[7:0];
            wire [3:0]  r    = rel[3:0];
            wire        pulse_mode = cfg_ff[g].control[
                `CTRL_MODE_HI_BIT:`CTRL_MODE_LO_BIT] == `MODE_PULSE_GEN;
            wire [1:0]  idle = cfg_ff[g].idle;
            wire        idle_low = pulse_mode &&
                                   idle == `IDLE_LOGIC_LOW;
            wire        idle_vcm = pulse_mode &&
                                   idle != `IDLE_NORMAL &&
                                   idle != `IDLE_LOGIC_LOW;
            wire        pair_clk = chan_src[g ^ 1];
            wire        div_one  = cfg_ff[g].divider == `DIV_ONE;
            wire        div_src  = div_one ? VCO_CLK
                                           : DIVIDER_CLK[g];
            logic       src_clk;
            logic       out_ff;
            logic [4:0] fine_app;
            logic [4:0] coarse_app;

            assign ch_hit[g] = hit;

            always_comb begin
                case (cfg_ff[g].source)
                    `SEL_DIVIDER: src_clk = div_src;
                    `SEL_ANALOG:  src_clk = ANALOG_DELAY_CLK[g];
                    `SEL_PAIR:    src_clk = pair_clk;
                    `SEL_VCO:     src_clk = VCO_CLK;
                    default:      src_clk = div_src;
                endcase
            end
            assign chan_src[g] = div_src;

            always_ff @(posedge CORE_CLK) begin
                if (SRST) begin
                    cfg_ff[g] <= '0;
                    cfg_ff[g].control[`CTRL_REPEAT_EN_BIT] <=
                        PULSE_CHANS[g] ? `REPEAT_RESET_PULSE
                                       : `REPEAT_RESET_DEVICE_CLOCK_OUTPUT;
                end else if (wr) begin
                    case (r)
                        4'h0: cfg_ff[g].control <= wd;
                        4'h1: cfg_ff[g].divider[7:0] <= wd;
                        4'h2: cfg_ff[g].divider[11:8] <= wd[3:0];
                        4'h3: cfg_ff[g].fine <= wd[4:0];
                        4'h4: cfg_ff[g].coarse <= wd[4:0];
                        4'h5: cfg_ff[g].repeat_count[7:0] <= wd;
                        4'h6: cfg_ff[g].repeat_count[11:8] <=
                            wd[3:0];
                        4'h7: cfg_ff[g].source <= wd[1:0];
                        4'h8: cfg_ff[g].idle <=
                            wd[`IDLE_HI_BIT:`IDLE_LO_BIT];
                        default: cfg_ff[g].source <= cfg_ff[g].source;
                    endcase
                end
            end

            always_comb begin
                case (r)
                    4'h0: ch_field[g] = {1'b0, cfg_ff[g].control};
                    4'h1: ch_field[g] = {1'b0, cfg_ff[g].divider[7:0]};
                    4'h2: ch_field[g] = {5'h00, cfg_ff[g].divider[11:8]};
                    4'h3: ch_field[g] = {4'h0, cfg_ff[g].fine};
                    4'h4: ch_field[g] = {4'h0, cfg_ff[g].coarse};
                    4'h5: ch_field[g] = {1'b0,
                                         cfg_ff[g].repeat_count[7:0]};
                    4'h6: ch_field[g] = {5'h00,
                                         cfg_ff[g].repeat_count[11:8]};
                    4'h7: ch_field[g] = {7'h00, cfg_ff[g].source};
                    4'h8: ch_field[g] = {1'b0, cfg_ff[g].idle, 6'h00};
                    default: ch_field[g] = 9'h000;
                endcase
            end

            delay_code_hold #(.LIMIT(`FINE_DELAY_MAX)) u_fine (
                .clk     (CORE_CLK),
                .srst    (SRST),
                .code    (cfg_ff[g].fine),
                .applied (fine_app)
            );

            delay_code_hold #(.LIMIT(`COARSE_DELAY_MAX)) u_coarse (
                .clk     (CORE_CLK),
                .srst    (SRST),
                .code    (cfg_ff[g].coarse),
                .applied (coarse_app)
            );

            slip_repeater #(.CW(12)) u_slip (
                .clk       (CORE_CLK),
                .srst      (SRST),
                .event_in  (slip_event),
                .slip_en   (cfg_ff[g].control[`CTRL_SLIP_EN_BIT]),
                .repeat_en (cfg_ff[g].control[`CTRL_REPEAT_EN_BIT]),
                .count     (cfg_ff[g].repeat_count),
                .shift     (shift_w[g])
            );

            always_ff @(posedge CORE_CLK) begin
                if (SRST) begin
                    out_ff <= 1'b0;
                end else begin
                    out_ff <= (idle_low || idle_vcm) ? 1'b0 : src_clk;
                end
            end

            assign CHANNEL_OUT[g]        = out_ff;
            assign IDLE_AT_VCM[g]        = idle_vcm;
            assign FINE_DELAY[g*5+:5]    = fine_app;
            assign COARSE_DELAY[g*5+:5]  = coarse_app;

            a_idle_gate: assert property (@(posedge CORE_CLK)
                disable iff (SRST)
                idle_low |=> !out_ff)
                else $error("idle low not forced");
            a_vcm_gate: assert property (@(posedge CORE_CLK)
                disable iff (SRST)
                idle_vcm |=> !out_ff)
                else $error("idle common mode not forced");
            a_vco_route: assert property (@(posedge CORE_CLK)
                disable iff (SRST)
                cfg_ff[g].source == `SEL_VCO && !idle_low && !idle_vcm
                |=> out_ff == $past(VCO_CLK))
                else $error("vco source not routed");
            a_div_one: assert property (@(posedge CORE_CLK)
                disable iff (SRST)
                cfg_ff[g].source == `SEL_DIVIDER && div_one &&
                !idle_low && !idle_vcm
                |=> out_ff == $past(VCO_CLK))
                else $error("divide by one not fundamental");
            a_div_route: assert property (@(posedge CORE_CLK)
                disable iff (SRST)
                cfg_ff[g].source == `SEL_DIVIDER && !div_one &&
                !idle_low && !idle_vcm
                |=> out_ff == $past(DIVIDER_CLK[g]))
                else $error("divider source not routed");
            a_analog_route: assert property (@(posedge CORE_CLK)
                disable iff (SRST)
                cfg_ff[g].source == `SEL_ANALOG && !idle_low && !idle_vcm
                |=> out_ff == $past(ANALOG_DELAY_CLK[g]))
                else $error("analog delay source not routed");
            a_pair_route: assert property (@(posedge CORE_CLK)
                disable iff (SRST)
                cfg_ff[g].source == `SEL_PAIR && !idle_low && !idle_vcm
                |=> out_ff == $past(chan_src[g ^ 1]))
                else $error("pair source not routed");
            a_repeat_default: assert property (@(posedge CORE_CLK)
                disable iff (SRST)
                $fell(SRST) |-> cfg_ff[g].control[`CTRL_REPEAT_EN_BIT] ==
                    (PULSE_CHANS[g] ? `REPEAT_RESET_PULSE
                                    : `REPEAT_RESET_DEVICE_CLOCK_OUTPUT))
                else $error("repeat allow reset value wrong");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // slip shift outputs and read path
    assign SLIP_SHIFT = shift_w;

    always_comb begin
        rd_mux = 32'h0000_0000;
        for (int i = 0; i < NCH; i++) begin
            if (ch_hit[i]) begin
                rd_mux = {23'h000000, ch_field[i]};
            end
        end
    end

    wire any_hit = (|ch_hit) || slip_hit;

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            prdata_ff <= 32'h0000_0000;
        end else if (PSEL && !PENABLE) begin
            prdata_ff <= 32'h0000_0000;
        end else if (apb_access && !PWRITE) begin
            prdata_ff <= rd_mux;
        end
    end

    assign PREADY  = 1'b1;
    assign PRDATA  = apb_access && !PWRITE ? rd_mux : prdata_ff;
    assign PSLVERR = apb_access && !any_hit;

    a_stride_decode: assert property (@(posedge CORE_CLK)
        disable iff (SRST)
        apb_wr && aligned &&
        word_idx == 12'(`CH0_SOURCE_SELECT_OFS + `CH_STRIDE)
        |=> cfg_ff[1].source == $past(PWDATA[1:0]))
        else $error("channel 1 source decode wrong");
    a_read_hold: assert property (@(posedge CORE_CLK)
        disable iff (SRST)
        $past(apb_access && !PWRITE) && !PSEL |-> PRDATA == $past(PRDATA))
        else $error("read data not held after access");
    a_unmapped_err: assert property (@(posedge CORE_CLK)
        disable iff (SRST)
        apb_access && !any_hit |-> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped access not refused");
endmodule

// >>> tb/clock_channel_delay_mux_bench.sv
/*
 self-checking bench for the channel delay and output mux block:
 apb register access, delay code limits, repeat-slip trains,
 source selection and idle level.
 assumes: map header on the include path, zero-wait apb slave.
*/
`include "chan_delay_map.svh"
module clock_channel_delay_mux_bench
    import chan_delay_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic            CORE_CLK;
    logic            SRST;
    logic            PSEL;
    logic            PENABLE;
    logic            PWRITE;
    logic [11:0]     PADDR;
    logic [31:0]     PWDATA;
    logic [31:0]     PRDATA;
    logic            PREADY;
    logic            PSLVERR;
    logic            GENERAL_INPUT_PIN_SLIP;
    logic            SYNC_SLIP;
    logic            PULSE_GEN_SLIP;
    logic [13:0]     DIVIDER_CLK;
    logic [13:0]     ANALOG_DELAY_CLK;
    logic            VCO_CLK;
    logic [13:0]     CHANNEL_OUT;
    logic [13:0]     IDLE_AT_VCM;
    logic [13:0]     SLIP_SHIFT;
    logic [69:0]     FINE_DELAY;
    logic [69:0]     COARSE_DELAY;
    int              err_count;
    int              checked;
    int              cycles;
    logic [31:0]     rd;
    logic            er;
    int              n0;
    int              n1;
    int              n2;
    logic            lv;

    clock_channel_delay_mux dut (
        .CORE_CLK               (CORE_CLK),
        .SRST                   (SRST),
        .PSEL                   (PSEL),
        .PENABLE                (PENABLE),
        .PWRITE                 (PWRITE),
        .PADDR                  (PADDR),
        .PWDATA                 (PWDATA),
        .PRDATA                 (PRDATA),
        .PREADY                 (PREADY),
        .PSLVERR                (PSLVERR),
        .GENERAL_INPUT_PIN_SLIP (GENERAL_INPUT_PIN_SLIP),
        .SYNC_SLIP              (SYNC_SLIP),
        .PULSE_GEN_SLIP         (PULSE_GEN_SLIP),
        .DIVIDER_CLK            (DIVIDER_CLK),
        .ANALOG_DELAY_CLK       (ANALOG_DELAY_CLK),
        .VCO_CLK                (VCO_CLK),
        .CHANNEL_OUT            (CHANNEL_OUT),
        .IDLE_AT_VCM            (IDLE_AT_VCM),
        .SLIP_SHIFT             (SLIP_SHIFT),
        .FINE_DELAY             (FINE_DELAY),
        .COARSE_DELAY           (COARSE_DELAY)
    );

////////////////////////////////////////////////////////////////////////
    initial begin
        CORE_CLK = 1'b0;
        forever #50 CORE_CLK = ~CORE_CLK;
    end

    always @(posedge CORE_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            err_count++;
            wrap_up();
        end
    end

////////////////////////////////////////////////////////////////////////
    function automatic logic [11:0] ra(input int c, input int k);
        ra = 12'((`CH0_CONTROL_OFS + c * 10 + k) * 4);
    endfunction

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge CORE_CLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= wr;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CORE_CLK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic slip_run(input int src);
        if (src == 3) begin
            apb(1'b1, 12'(`SLIP_REQUEST_ADDR * 4), 32'h0000_0001);
        end else begin
            @(posedge CORE_CLK);
            GENERAL_INPUT_PIN_SLIP <= (src == 0);
            SYNC_SLIP              <= (src == 1);
            PULSE_GEN_SLIP         <= (src == 2);
            @(posedge CORE_CLK);
            GENERAL_INPUT_PIN_SLIP <= 1'b0;
            SYNC_SLIP              <= 1'b0;
            PULSE_GEN_SLIP         <= 1'b0;
        end
        n0 = 0;
        n1 = 0;
        n2 = 0;
        repeat (300) begin
            @(posedge CORE_CLK);
            n0 += int'(SLIP_SHIFT[0] === 1'b1);
            n1 += int'(SLIP_SHIFT[1] === 1'b1);
            n2 += int'(SLIP_SHIFT[2] === 1'b1);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

////////////////////////////////////////////////////////////////////////
    initial begin
        err_count = 0;
        checked = 0;
        cycles = 0;
        SRST = 1'b1;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 12'h000;
        PWDATA = 32'h0000_0000;
        GENERAL_INPUT_PIN_SLIP = 1'b0;
        SYNC_SLIP = 1'b0;
        PULSE_GEN_SLIP = 1'b0;
        DIVIDER_CLK = 14'h0000;
        ANALOG_DELAY_CLK = 14'h0000;
        VCO_CLK = 1'b0;
        repeat (6) @(posedge CORE_CLK);
        SRST <= 1'b0;
        // reset defaults and unmapped access
        apb(1'b0, ra(0, 0), 32'h0);
        chk("ch0 control", 32'h0000_0002, rd);
        apb(1'b0, ra(1, 0), 32'h0);
        chk("ch1 control", 32'h0000_0000, rd);
        apb(1'b1, ra(1, 7), 32'h0000_0002);
        apb(1'b0, ra(1, 7), 32'h0);
        chk("ch1 source", 32'h0000_0002, rd);
        apb(1'b0, 12'h000, 32'h0);
        chk("unmapped err", 32'h0000_0001, {31'h0, er});
        chk("unmapped data", 32'h0000_0000, rd);
        // fine delay on ch3, limit and above
        apb(1'b1, ra(3, 3), 32'h0000_0017);
        apb(1'b0, ra(3, 3), 32'h0);
        chk("fine readback", 32'h0000_0017, rd);
        apb(1'b1, ra(3, 3), 32'h0000_0018);
        repeat (4) @(posedge CORE_CLK);
        chk("fine applied", 32'h17, {27'h0, FINE_DELAY[19:15]});
        // coarse delay on last channel
        apb(1'b1, ra(13, 4), 32'h0000_0011);
        repeat (4) @(posedge CORE_CLK);
        chk("coarse max", 32'h11, {27'h0, COARSE_DELAY[69:65]});
        apb(1'b1, ra(13, 4), 32'h0000_0012);
        repeat (4) @(posedge CORE_CLK);
        chk("coarse hold", 32'h11, {27'h0, COARSE_DELAY[69:65]});
        // repeat count 0x103 on ch0, single slip on ch2
        apb(1'b1, ra(0, 5), 32'h0000_0003);
        apb(1'b1, ra(0, 6), 32'h0000_0001);
        apb(1'b1, ra(0, 0), 32'h0000_0023);
        apb(1'b1, ra(2, 0), 32'h0000_0021);
        for (int s = 0; s < 4; s++) begin
            slip_run(s);
            chk("ch0 train", 32'd259, 32'(n0));
            chk("ch2 single", 32'd1, 32'(n2));
            chk("ch1 none", 32'd0, 32'(n1));
        end
        // repeat count of two on ch0
        apb(1'b1, ra(0, 5), 32'h0000_0002);
        apb(1'b1, ra(0, 6), 32'h0000_0000);
        slip_run(1);
        chk("ch0 train two", 32'd2, 32'(n0));
        // source select on ch4, pair is ch5 divider path
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, ra(4, 7), 32'(s));
            apb(1'b0, ra(4, 7), 32'h0);
            chk("source readback", 32'(s), rd);
            for (int v = 0; v < 2; v++) begin
                lv = v[0];
                DIVIDER_CLK[4] <= (s == 0) ? lv : ~lv;
                ANALOG_DELAY_CLK[4] <= (s == 1) ? lv : ~lv;
                DIVIDER_CLK[5] <= (s == 2) ? lv : ~lv;
                VCO_CLK <= (s == 3) ? lv : ~lv;
                repeat (3) @(posedge CORE_CLK);
                chk("ch4 out", {31'h0, lv}, {31'h0, CHANNEL_OUT[4]});
            end
        end
        // divider setpoint one gives the vco clock
        apb(1'b1, ra(4, 7), 32'h0000_0000);
        apb(1'b1, ra(4, 1), 32'h0000_0001);
        for (int v = 0; v < 2; v++) begin
            lv = v[0];
            VCO_CLK <= lv;
            DIVIDER_CLK[4] <= ~lv;
            repeat (3) @(posedge CORE_CLK);
            chk("div one out", {31'h0, lv}, {31'h0, CHANNEL_OUT[4]});
        end
        // idle level on pulse channel ch7 only
        DIVIDER_CLK[7] <= 1'b1;
        apb(1'b1, ra(7, 8), 32'h0000_0040);
        apb(1'b1, ra(7, 0), 32'h0000_0001);
        repeat (2) @(posedge CORE_CLK);
        chk("idle async", 32'h0, {31'h0, IDLE_AT_VCM[7]});
        chk("ch7 out async", 32'h1, {31'h0, CHANNEL_OUT[7]});
        apb(1'b1, ra(7, 0), 32'h0000_000D);
        repeat (2) @(posedge CORE_CLK);
        chk("idle pulse", 32'h1, {31'h0, IDLE_AT_VCM[7]});
        chk("ch7 out vcm", 32'h0, {31'h0, CHANNEL_OUT[7]});
        apb(1'b1, ra(7, 8), 32'h0000_0080);
        repeat (2) @(posedge CORE_CLK);
        chk("idle low", 32'h0, {31'h0, IDLE_AT_VCM[7]});
        chk("ch7 out low", 32'h0, {31'h0, CHANNEL_OUT[7]});
        apb(1'b0, ra(7, 8), 32'h0);
        chk("idle readback", 32'h80, rd & 32'h0000_00C0);
        wrap_up();
    end

endmodule
